// ==== logic/agc_pkg.sv ====
// Purpose: Shared constants, types and decoders for the gain limit and
//          carrier sense block.
// Assumes: Registers are eight bits wide and sit in the low byte of a word.
// Notes:   Register indices times four give the Wishbone byte address.
package agc_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam logic [5:0] IDX_CEIL_SET = 6'h1b;
  localparam logic [5:0] IDX_ORDER_SENSE = 6'h1c;
  localparam logic [5:0] IDX_STATUS = 6'h30;
  localparam logic [5:0] IDX_MASK = 6'h31;
  localparam logic [5:0] IDX_GAIN = 6'h32;
  localparam logic [5:0] IDX_RSSI = 6'h33;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int DG_CEIL_LSB = 6;
  localparam int FA_CEIL_LSB = 3;
  localparam int SETPT_LSB = 0;
  localparam int ORDER_BIT = 6;
  localparam int REL_LSB = 4;
  localparam int ABS_LSB = 0;
  localparam logic [7:0] CEIL_SET_RST = 8'h03;
  localparam logic [6:0] ORDER_SENSE_RST = 7'h40;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [3:0] ABS_DISABLE = 4'h8;

  // ---------------------------------------------------------------------
  // Status bits and gain scale
  // ---------------------------------------------------------------------
  localparam int ST_W = 3;
  localparam int ST_CS_RISE = 0;
  localparam int ST_CS_FALL = 1;
  localparam int ST_GAIN_CHG = 2;
  localparam logic [2:0] RED_MAX = 3'h7;
  localparam logic [3:0] DG_STEP_DB = 4'h3;
  localparam logic [3:0] FA_STEP_DB = 4'h2;

  // Reductions per stage; zero means the highest gain of that stage.
  typedef struct packed {
    logic [2:0] dg_red;
    logic [2:0] lna1_red;
    logic [2:0] second_low_noise_amp_red;
  } agc_gain_t;

  // Amplitude setpoint in dB for each code.
  function automatic logic [7:0] setpoint_db(input logic [2:0] code);
    case (code)
      3'h0: setpoint_db = 8'h18;
      3'h1: setpoint_db = 8'h1b;
      3'h2: setpoint_db = 8'h1e;
      3'h3: setpoint_db = 8'h21;
      3'h4: setpoint_db = 8'h24;
      3'h5: setpoint_db = 8'h26;
      3'h6: setpoint_db = 8'h28;
      default: setpoint_db = 8'h2a;
    endcase
  endfunction

  // Relative rise in dB for each enabled code.
  function automatic logic [7:0] rel_rise_db(input logic [1:0] code);
    case (code)
      2'h1: rel_rise_db = 8'h06;
      2'h2: rel_rise_db = 8'h0a;
      default: rel_rise_db = 8'h0e;
    endcase
  endfunction

endpackage

// ==== logic/agc_gain_step.sv ====
// Purpose: Next gain setting of the gain loop for one amplitude sample.
// Assumes: Called once per valid channel filter sample.
// Notes:   Purely combinational; the caller holds the gain state.
`timescale 1ns/100ps
module agc_gain_step (
  input wire logic [7:0] amp_in,
  input wire logic [7:0] setpoint_in,
  input wire logic [1:0] dg_ceil_in,
  input wire logic [2:0] fa_ceil_in,
  input wire logic order_in,
  input wire agc_pkg::agc_gain_t gain_in,
  output agc_pkg::agc_gain_t gain_out
);
  import agc_pkg::*;

  logic [3:0] fa_sum;

  // Ceilings are enforced first, then one step toward the setpoint.
  always_comb begin
    gain_out = gain_in;
    fa_sum = {1'b0, gain_in.lna1_red} + {1'b0, gain_in.second_low_noise_amp_red};
    if (gain_in.dg_red < {1'b0, dg_ceil_in}) begin
      gain_out.dg_red = {1'b0, dg_ceil_in}; // R1
    end else if (fa_sum < {1'b0, fa_ceil_in} || amp_in > setpoint_in) begin
      // Lower the front amps in the chosen order, else the digital stage.
      if (order_in && gain_in.lna1_red != RED_MAX) begin
        gain_out.lna1_red = gain_in.lna1_red + 3'h1; // R4
      end else if (gain_in.second_low_noise_amp_red != RED_MAX) begin
        gain_out.second_low_noise_amp_red = gain_in.second_low_noise_amp_red + 3'h1; // R4
      end else if (gain_in.lna1_red != RED_MAX) begin
        gain_out.lna1_red = gain_in.lna1_red + 3'h1; // R4
      end else if (gain_in.dg_red != RED_MAX &&
                   fa_sum >= {1'b0, fa_ceil_in}) begin
        gain_out.dg_red = gain_in.dg_red + 3'h1;
      end
    end else if (amp_in < setpoint_in) begin // R3
      // Raise the digital stage first, then undo front reductions.
      if (gain_in.dg_red > {1'b0, dg_ceil_in}) begin
        gain_out.dg_red = gain_in.dg_red - 3'h1; // R1
      end else if (fa_sum > {1'b0, fa_ceil_in}) begin // R2
        if (order_in ? gain_in.second_low_noise_amp_red != 3'h0
                     : gain_in.lna1_red == 3'h0) begin
          gain_out.second_low_noise_amp_red = gain_in.second_low_noise_amp_red - 3'h1; // R4
        end else begin
          gain_out.lna1_red = gain_in.lna1_red - 3'h1; // R4
        end
      end
    end
  end

endmodule

// ==== logic/agc_carrier_sense.sv ====
// Purpose: Carrier sense decision from signal strength and thresholds.
// Assumes: Signal strength and baseline are in dB on the same scale.
// Notes:   Purely combinational.
`timescale 1ns/100ps
module agc_carrier_sense (
  input wire logic [7:0] rssi_in,
  input wire logic [7:0] baseline_in,
  input wire logic base_valid_in,
  input wire logic [7:0] setpoint_in,
  input wire logic [1:0] rel_code_in,
  input wire logic [3:0] abs_code_in,
  output logic sense_out
);
  import agc_pkg::*;

  logic signed [9:0] abs_thr;
  logic [8:0] rel_thr;
  logic abs_hit;
  logic rel_hit;

  // Absolute level is the setpoint plus a signed offset in 1 dB steps.
  always_comb begin
    abs_thr = $signed({2'b00, setpoint_in}) +
              $signed({{6{abs_code_in[3]}}, abs_code_in}); // R6
    abs_hit = abs_code_in != ABS_DISABLE &&
              $signed({2'b00, rssi_in}) >= abs_thr; // R7
    rel_thr = {1'b0, baseline_in} + {1'b0, rel_rise_db(rel_code_in)};
    rel_hit = rel_code_in != 2'h0 && base_valid_in &&
              {1'b0, rssi_in} >= rel_thr; // R5
    sense_out = abs_hit || rel_hit; // R9
  end

endmodule

// ==== logic/agc_gain_ctrl.sv ====
// Functional notes
// R1: The two-bit digital ceiling code 0..3 keeps the top 0..3 steps unused.
// R2: The three-bit front ceiling code raises the least combined reduction.
// R3: The setpoint code selects 24, 27, 30, 33, 36, 38, 40 or 42 dB.
// R4: Order bit 1 lowers the first amp first; 0 drains the second first.
// R5: Relative code 0 is off; 1..3 sense a rise of 6, 10 or 14 dB.
// R6: The absolute code is a signed offset in dB from the setpoint.
// R7: Absolute code minus eight disables the absolute check.
// R8: Signal strength equals the amplitude while no gain is reduced.
// R9: Carrier sense is the OR of enabled checks and low if none enabled.
//
// Purpose: Gain limits, gain loop and carrier sense with a Wishbone slave.
// Assumes: Amplitude samples come from logic on the same clock.
// Notes:   Reads of the status register clear it; new events still land.
`timescale 1ns/100ps
module agc_gain_ctrl #(
  parameter int AMP_W = 8
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [agc_pkg::ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [agc_pkg::DAT_W-1:0] WB_DAT_IN,
  output logic [agc_pkg::DAT_W-1:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic [AMP_W-1:0] AMP_IN,
  input wire logic AMP_VALID_IN,
  output logic [2:0] DIGITAL_GAIN_RED_OUT,
  output logic [2:0] LNA1_GAIN_RED_OUT,
  output logic [2:0] SECOND_LOW_NOISE_AMP_GAIN_RED_OUT,
  output logic [7:0] RSSI_OUT,
  output logic CARRIER_SENSE_OUT,
  output logic IRQ_OUT
);
  import agc_pkg::*;

  // -----------------------------------------------------------------------
  // Parameter check
  // -----------------------------------------------------------------------
  generate
    if (AMP_W != 8) begin : g_bad_width
      $error("AMP_W must be 8 to match the dB scale");
    end
  endgenerate

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ceil_set;
    logic [6:0] order_sense;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    agc_gain_t gain;
    logic [7:0] rssi;
    logic [7:0] baseline;
    logic base_valid;
    logic sense;
    logic ack;
    logic [7:0] rdata;
    logic irq;
  } agc_state_t;

  agc_state_t st;
  agc_state_t next_st;
  agc_gain_t step_gain;
  logic [7:0] setpoint;
  logic [7:0] rssi_now;
  logic sense_now;
  logic access;
  logic wr_low;
  logic [5:0] idx;
  logic [9:0] red_db;
  logic [9:0] rssi_sum;
  logic [ST_W-1:0] events;

  // Setpoint decoded once for both the loop and the absolute check.
  assign setpoint = setpoint_db(st.ceil_set[SETPT_LSB +: 3]); // R3

  // -----------------------------------------------------------------------
  // Signal strength scale
  // -----------------------------------------------------------------------
  // Strength is amplitude plus the gain removed, so no reduction gives
  // amplitude itself; the sum saturates rather than wrapping.
  always_comb begin
    red_db = 10'(st.gain.dg_red) * 10'(DG_STEP_DB) +
             (10'(st.gain.lna1_red) + 10'(st.gain.second_low_noise_amp_red)) *
             10'(FA_STEP_DB);
    rssi_sum = {2'b00, AMP_IN} + red_db; // R8
    rssi_now = (rssi_sum > 10'h0ff) ? 8'hff : rssi_sum[7:0];
  end

  // -----------------------------------------------------------------------
  // Gain loop and carrier sense decision
  // -----------------------------------------------------------------------
  agc_gain_step u_gain_step (
    .amp_in(AMP_IN),
    .setpoint_in(setpoint),
    .dg_ceil_in(st.ceil_set[DG_CEIL_LSB +: 2]),
    .fa_ceil_in(st.ceil_set[FA_CEIL_LSB +: 3]),
    .order_in(st.order_sense[ORDER_BIT]),
    .gain_in(st.gain),
    .gain_out(step_gain)
  );

  agc_carrier_sense u_carrier_sense (
    .rssi_in(rssi_now),
    .baseline_in(st.baseline),
    .base_valid_in(st.base_valid),
    .setpoint_in(setpoint),
    .rel_code_in(st.order_sense[REL_LSB +: 2]),
    .abs_code_in(st.order_sense[ABS_LSB +: 4]),
    .sense_out(sense_now)
  );

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  // Bus access, register writes, gain update, sense tracking and events.
  always_comb begin
    next_st = st;
    idx = WB_ADR_IN[7:2];
    access = WB_CYC_IN && WB_STB_IN && !st.ack;
    wr_low = access && WB_WE_IN && WB_SEL_IN[0];
    events = '0;
    next_st.ack = access;

    // Read data is captured with the acknowledge; unmapped reads give 0.
    if (access && !WB_WE_IN) begin
      case (idx)
        IDX_CEIL_SET: next_st.rdata = st.ceil_set;
        IDX_ORDER_SENSE: next_st.rdata = {1'b0, st.order_sense};
        IDX_STATUS: next_st.rdata = {{(8-ST_W){1'b0}}, st.status};
        IDX_MASK: next_st.rdata = {{(8-ST_W){1'b0}}, st.mask};
        IDX_GAIN: next_st.rdata = {2'b00, st.gain.second_low_noise_amp_red,
                                   st.gain.dg_red};
        IDX_RSSI: next_st.rdata = st.rssi;
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Writes of the low byte; the top bit of the second register stays 0.
    if (wr_low) begin
      case (idx)
        IDX_CEIL_SET: next_st.ceil_set = WB_DAT_IN[7:0];
        IDX_ORDER_SENSE: begin
          next_st.order_sense = WB_DAT_IN[6:0];
          next_st.base_valid = 1'b0;
        end
        IDX_MASK: next_st.mask = WB_DAT_IN[ST_W-1:0];
        default: next_st.mask = next_st.mask;
      endcase
    end

    // A status read clears it before this cycle's events are merged.
    if (access && !WB_WE_IN && idx == IDX_STATUS) begin
      next_st.status = '0;
    end

    // Each amplitude sample moves the gain and refreshes carrier sense.
    if (AMP_VALID_IN) begin
      next_st.gain = step_gain; // R1
      next_st.rssi = rssi_now;
      next_st.sense = sense_now; // R9
      if (!sense_now && (!st.base_valid || rssi_now < st.baseline)) begin
        next_st.baseline = rssi_now; // R5
        next_st.base_valid = 1'b1;
      end
      events[ST_CS_RISE] = sense_now && !st.sense;
      events[ST_CS_FALL] = !sense_now && st.sense;
      events[ST_GAIN_CHG] = step_gain != st.gain;
    end

    // Set wins over the read clear.
    next_st.status = next_st.status | events;
    next_st.irq = |(next_st.status & next_st.mask);
  end

  // -----------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st <= '0;
      st.ceil_set <= CEIL_SET_RST;
      st.order_sense <= ORDER_SENSE_RST;
      st.mask <= MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  // All outputs are straight register bits.
  assign WB_DAT_OUT = {24'h000000, st.rdata};
  assign WB_ACK_OUT = st.ack;
  assign DIGITAL_GAIN_RED_OUT = st.gain.dg_red;
  assign LNA1_GAIN_RED_OUT = st.gain.lna1_red;
  assign SECOND_LOW_NOISE_AMP_GAIN_RED_OUT = st.gain.second_low_noise_amp_red;
  assign RSSI_OUT = st.rssi;
  assign CARRIER_SENSE_OUT = st.sense;
  assign IRQ_OUT = st.irq;

endmodule

// ==== dv/agc_gain_ctrl_checker.sv ====
// Purpose: Concurrent checks on the gain limit and carrier sense block.
// Assumes: Register fields are mirrored here from taken Wishbone writes.
// Notes:   Gains and carrier sense are judged around valid samples; sense is also checked to hold between them.
`timescale 1ns/100ps
module agc_gain_ctrl_checker #(
  parameter int AMP_W = 8
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [agc_pkg::ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [agc_pkg::DAT_W-1:0] WB_DAT_IN,
  input wire logic [agc_pkg::DAT_W-1:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire logic [AMP_W-1:0] AMP_IN,
  input wire logic AMP_VALID_IN,
  input wire logic [2:0] DIGITAL_GAIN_RED_OUT,
  input wire logic [2:0] LNA1_GAIN_RED_OUT,
  input wire logic [2:0] SECOND_LOW_NOISE_AMP_GAIN_RED_OUT,
  input wire logic [7:0] RSSI_OUT,
  input wire logic CARRIER_SENSE_OUT,
  input wire logic IRQ_OUT
);
  import agc_pkg::*;
  localparam logic [63:0] SP_TAB = 64'h2a282624211e1b18;
  logic [7:0] ceil_set;
  logic [6:0] ord_sense;
  logic [1:0] dg_ceil;
  logic [3:0] fa_ceil;
  logic [3:0] fa_sum;
  logic [8:0] abs_thr;
  logic wr_take;
  logic [9:0] rssi_full;
  logic [7:0] rssi_exp;

  // ---------------------------------------------------------------------
  // Register mirror
  // ---------------------------------------------------------------------
  // A write lands at the edge that takes it, as the slave does.
  assign wr_take = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !WB_ACK_OUT
                   && WB_SEL_IN[0];
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ceil_set <= CEIL_SET_RST;
      ord_sense <= ORDER_SENSE_RST;
    end else if (wr_take && WB_ADR_IN[7:2] == IDX_CEIL_SET) begin
      ceil_set <= WB_DAT_IN[7:0];
    end else if (wr_take && WB_ADR_IN[7:2] == IDX_ORDER_SENSE) begin
      ord_sense <= WB_DAT_IN[6:0];
    end
  end
  // Ceilings and absolute threshold from the mirror; front sum from the gain outputs.
  assign dg_ceil = ceil_set[7:6];
  assign fa_ceil = {1'b0, ceil_set[5:3]};
  assign fa_sum = {1'b0, LNA1_GAIN_RED_OUT} + {1'b0, SECOND_LOW_NOISE_AMP_GAIN_RED_OUT};
  assign abs_thr = {1'b0, SP_TAB[{ceil_set[2:0], 3'h0} +: 8]}
                   + {{5{ord_sense[3]}}, ord_sense[3:0]};

  // Strength is amplitude plus the removed gain, saturated at full scale.
  assign rssi_full = 10'(AMP_IN) +
                     10'(DIGITAL_GAIN_RED_OUT) * 10'(DG_STEP_DB) +
                     (10'(LNA1_GAIN_RED_OUT) + 10'(SECOND_LOW_NOISE_AMP_GAIN_RED_OUT)) *
                     10'(FA_STEP_DB);
  assign rssi_exp = (rssi_full > 10'h0ff) ? 8'hff : rssi_full[7:0];

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  property p_dg_ceil;
    AMP_VALID_IN && DIGITAL_GAIN_RED_OUT >= dg_ceil
      |=> DIGITAL_GAIN_RED_OUT >= $past(dg_ceil);
  endproperty
  a_dg_ceil: assert property (p_dg_ceil)
    else $error("digital gain above its ceiling");
  property p_fa_ceil;
    AMP_VALID_IN && fa_sum >= fa_ceil |=> fa_sum >= $past(fa_ceil);
  endproperty
  a_fa_ceil: assert property (p_fa_ceil)
    else $error("front gain above its ceiling");
  property p_second_low_noise_amp_first;
    AMP_VALID_IN && !ord_sense[6] ##1
      LNA1_GAIN_RED_OUT > $past(LNA1_GAIN_RED_OUT)
      |-> $past(SECOND_LOW_NOISE_AMP_GAIN_RED_OUT) == 3'h7;
  endproperty
  a_second_low_noise_amp_first: assert property (p_second_low_noise_amp_first)
    else $error("first amp cut before second at minimum");
  property p_lna1_first;
    AMP_VALID_IN && ord_sense[6] ##1
      SECOND_LOW_NOISE_AMP_GAIN_RED_OUT > $past(SECOND_LOW_NOISE_AMP_GAIN_RED_OUT)
      |-> $past(LNA1_GAIN_RED_OUT) == 3'h7;
  endproperty
  a_lna1_first: assert property (p_lna1_first)
    else $error("second amp cut before first at minimum");
  property p_abs_sense;
    AMP_VALID_IN && ord_sense[5:4] == 2'h0 && ord_sense[3:0] != ABS_DISABLE
      |=> CARRIER_SENSE_OUT == ({1'b0, RSSI_OUT} >= $past(abs_thr));
  endproperty
  a_abs_sense: assert property (p_abs_sense)
    else $error("absolute sense wrong");
  property p_abs_off;
    AMP_VALID_IN && ord_sense[5:4] == 2'h0 && ord_sense[3:0] == ABS_DISABLE
      |=> !CARRIER_SENSE_OUT;
  endproperty
  a_abs_off: assert property (p_abs_off)
    else $error("sense high with both checks off");
  property p_rssi_base;
    AMP_VALID_IN && DIGITAL_GAIN_RED_OUT == 3'h0 && fa_sum == 4'h0
      |=> RSSI_OUT == $past(AMP_IN);
  endproperty
  a_rssi_base: assert property (p_rssi_base)
    else $error("strength differs from amplitude");
  property p_rssi_scale;
    AMP_VALID_IN |=> RSSI_OUT == $past(rssi_exp);
  endproperty
  a_rssi_scale: assert property (p_rssi_scale)
    else $error("strength scale wrong under gain reduction");
  property p_cs_hold;
    !AMP_VALID_IN |=> $stable(CARRIER_SENSE_OUT);
  endproperty
  a_cs_hold: assert property (p_cs_hold)
    else $error("sense moved without a sample");
  property p_ack_pulse;
    WB_ACK_OUT |=> !WB_ACK_OUT;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  c_cs_rise: cover property ($rose(CARRIER_SENSE_OUT));
  c_irq: cover property ($rose(IRQ_OUT));
  c_dg_max: cover property (DIGITAL_GAIN_RED_OUT == 3'h7);
endmodule

bind agc_gain_ctrl agc_gain_ctrl_checker #(.AMP_W(AMP_W))
  agc_gain_ctrl_checker_inst (.SYS_CLK_IN, .RESET_N_IN, .WB_CYC_IN,
  .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN, .WB_DAT_OUT,
  .WB_ACK_OUT, .AMP_IN, .AMP_VALID_IN, .DIGITAL_GAIN_RED_OUT,
  .LNA1_GAIN_RED_OUT, .SECOND_LOW_NOISE_AMP_GAIN_RED_OUT, .RSSI_OUT, .CARRIER_SENSE_OUT,
  .IRQ_OUT);

// ==== dv/test_agc_gain_ctrl.sv ====
// Purpose: Self-checking bench for the gain limit and carrier sense block.
// Assumes: Registers are reached by classic Wishbone single cycles.
// Notes:   Amplitudes reach up to 7 dB above the setpoint in the sense tests and full scale in the gain tests.
`timescale 1ns/100ps
module test_agc_gain_ctrl;
  import agc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [DAT_W-1:0] wdat = 32'h0;
  logic [7:0] amp = 8'h00;
  logic amp_vld = 1'b0;
  logic [DAT_W-1:0] rdat;
  logic ack, cs, irq;
  logic [2:0] dg, l1, l2;
  logic [7:0] rssi;
  logic [31:0] q;
  logic [31:0] rnd = 32'h5eaa;
  int n_fail = 0;
  int checked = 0;

  // Free running clock of 50 ns.
  always #25 clk = ~clk;

  agc_gain_ctrl agc_gain_ctrl_inst (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .AMP_IN(amp), .AMP_VALID_IN(amp_vld), .DIGITAL_GAIN_RED_OUT(dg),
    .LNA1_GAIN_RED_OUT(l1), .SECOND_LOW_NOISE_AMP_GAIN_RED_OUT(l2), .RSSI_OUT(rssi),
    .CARRIER_SENSE_OUT(cs), .IRQ_OUT(irq));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Setpoint in dB: 3 dB steps up to code 4, then 2 dB steps.
  function automatic logic [7:0] sp_db(input logic [2:0] c);
    return (c < 3'h5) ? 8'h18 + 8'h03 * c : 8'h1c + 8'h02 * c;
  endfunction
  task automatic test_done();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [5:0] idx,
                    input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    sel <= s;
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      n++;
      if (n > 8) begin
        n_fail++;
        test_done();
      end
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // A burst of k back to back samples of one amplitude.
  task automatic smp(input logic [7:0] a, input int k);
    amp <= a;
    amp_vld <= 1'b1;
    repeat (k) @(posedge clk);
    amp_vld <= 1'b0;
    @(posedge clk);
  endtask

  // Main sequence.
  initial begin
    int t;
    logic [3:0] ab;
    logic [2:0] fc;
    logic [1:0] dc;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, IDX_CEIL_SET, 8'h00, 4'h1);
    chk("ceil_rst", q, 32'h03);
    wb(1'b0, IDX_ORDER_SENSE, 8'h00, 4'h1);
    chk("order_rst", q, 32'h40);
    wb(1'b1, IDX_ORDER_SENSE, 8'hc8, 4'h1);
    wb(1'b1, IDX_CEIL_SET, 8'hff, 4'h0);
    wb(1'b1, 6'h3f, 8'h55, 4'h1);
    wb(1'b0, IDX_ORDER_SENSE, 8'h00, 4'h1);
    chk("reserved", q, 32'h48);
    wb(1'b0, IDX_CEIL_SET, 8'h00, 4'h1);
    chk("sel_off", q, 32'h03);
    wb(1'b0, 6'h3f, 8'h00, 4'h1);
    chk("unmapped", q, 32'h0);
    // Every setpoint code with a random offset from -7 to +7 dB.
    for (int c = 0; c < 8; c++) begin
      rnd = xs(rnd);
      ab = 4'(rnd % 15) - 4'h7;
      t = int'(sp_db(3'(c))) + int'($signed(ab));
      wb(1'b1, IDX_CEIL_SET, 8'(c), 4'h1);
      wb(1'b1, IDX_ORDER_SENSE, {4'h4, ab}, 4'h1);
      smp(8'h00, 3);
      smp(8'(t - 1), 1);
      chk("rssi", {24'h0, rssi}, 32'(t - 1));
      chk("cs_below", {31'h0, cs}, 32'h0);
      smp(8'h00, 3);
      smp(8'(t), 1);
      chk("cs_at", {31'h0, cs}, 32'h1);
    end
    wb(1'b1, IDX_ORDER_SENSE, 8'h48, 4'h1);
    smp(8'h2a, 1);
    chk("abs_off", {31'h0, cs}, 32'h0);
    // Relative rises over a baseline rearmed by each write.
    for (int r = 1; r < 4; r++) begin
      t = 2 + 4 * r;
      wb(1'b1, IDX_ORDER_SENSE, {2'h1, 2'(r), 4'h8}, 4'h1);
      smp(8'h14, 1);
      chk("rel_base", {31'h0, cs}, 32'h0);
      smp(8'(20 + t - 1), 1);
      chk("rel_low", {31'h0, cs}, 32'h0);
      smp(8'(20 + t), 1);
      chk("rel_hit", {31'h0, cs}, 32'h1);
    end
    // Carrier rise raised masked, then unmasked, then cleared by a read.
    wb(1'b1, IDX_ORDER_SENSE, 8'h48, 4'h1);
    smp(8'h14, 1);
    wb(1'b0, IDX_STATUS, 8'h00, 4'h1);
    wb(1'b1, IDX_ORDER_SENSE, 8'h40, 4'h1);
    smp(8'h2a, 1);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wb(1'b1, IDX_MASK, 8'h01, 4'h1);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wb(1'b0, IDX_STATUS, 8'h00, 4'h1);
    chk("status", q, 32'h1);
    chk("irq_off", {31'h0, irq}, 32'h0);
    // Random ceilings under both reduction orders.
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      dc = rnd[1:0];
      fc = rnd[4:2];
      wb(1'b1, IDX_CEIL_SET, {dc, fc, 3'h0}, 4'h1);
      wb(1'b1, IDX_ORDER_SENSE, {1'b0, i[0], 6'h08}, 4'h1);
      smp(8'hff, 32);
      chk("dg_max", {29'h0, dg}, 32'h7);
      smp(8'h00, 32);
      chk("dg", {29'h0, dg}, {30'h0, dc});
      chk("lna1", {29'h0, l1}, i[0] ? {29'h0, fc} : 32'h0);
      chk("second_low_noise_amp", {29'h0, l2}, i[0] ? 32'h0 : {29'h0, fc});
      wb(1'b0, IDX_GAIN, 8'h00, 4'h1);
      chk("gain_rd", q, {26'h0, i[0] ? 3'h0 : fc, 1'b0, dc});
    end
    // Sense fell and the gains moved in the loop above; both bits latch.
    wb(1'b0, IDX_STATUS, 8'h00, 4'h1);
    chk("st_fall_gain", q, 32'h6);
    chk("irq_still_off", {31'h0, irq}, 32'h0);
    test_done();
  end
endmodule
